//--- hw/sideband_params.svh
/*
  Constants for the processor sideband control block: synchroniser depth,
  control-register-0 bit position, local interrupt defaults.
  Assumes inclusion by the design modules and the testbench files.
*/
`ifndef SIDEBAND_PARAMS_SVH
`define SIDEBAND_PARAMS_SVH

`define SYNC_STAGES 2
`define CR0_NATIVE_ERR_BIT 5
`define LOCAL_CTRL_RESET_EN 1'b1
`define MCLK_PERIOD_NS 40

`endif

//--- hw/sideband_pkg.sv
/*
  Types for the processor sideband control block.
  Assumes the constants header sits in the same folder.
*/
package sideband_pkg;
  // synchronised asynchronous inputs travel together
  typedef struct packed {
    logic ignoreNumericErrorN;
    logic softInitN;
    logic localIrqPinZero;
    logic localIrqPinOne;
  } async_in_s;

  // core-side status travelling out as one bundle
  typedef struct packed {
    logic maskableIrqRequest;
    logic nonmaskableIrq;
    logic localIrqZero;
    logic localIrqOne;
  } irq_out_s;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_INIT = 2'b01,
    ST_BIST = 2'b11
  } run_state_e;
endpackage

//--- hw/sync_level.sv
/*
  Two-flop level synchroniser, one instance per asynchronous input bit.
  Assumes a single mclk domain and asynchronous active-low reset.
*/
`timescale 1ns/10ps
`include "sideband_params.svh"

module sync_level #(
  parameter int STAGES = `SYNC_STAGES,
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic asyncIn,
  output logic syncOut
);
  logic [STAGES-1:0] stage_ff;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      stage_ff <= {STAGES{RESET_VAL}};
    else
      stage_ff <= {stage_ff[STAGES-2:0], asyncIn};
  end

  // only the last stage is ever read
  assign syncOut = stage_ff[STAGES-1];
endmodule

//--- hw/processor_sideband_control.sv
/*
  Processor sideband control: snoop stall, bus lock, internal error,
  numeric-error ignore, soft init with self-test, local interrupt pins,
  interrupt message bus pass-through and probe handshake.
  Assumes a core that supplies events and a bus on mclk; open-drain pins
  are split into in/out/enable, enable low while driven.
*/
`timescale 1ns/10ps
`include "sideband_params.svh"

module processor_sideband_control (
  input wire logic mclk,
  input wire logic resetn,
  // snoop result pins (open drain)
  input wire logic snoopHitInN,
  input wire logic snoop_hit_modified_in_n,
  output logic snoopHitOutN,
  output logic snoopHitOeN,
  output logic snoop_hit_modified_out_n,
  output logic snoopHitModifiedOeN,
  // core snoop interface
  input wire logic coreSnoopValid,
  input wire logic coreSnoopHit,
  input wire logic coreSnoopModified,
  input wire logic coreSnoopStall,
  output logic snoopServiced,
  output logic peerSnoopStall,
  // bus lock
  input wire logic busLockInN,
  output logic busLockOutN,
  output logic busLockOeN,
  input wire logic coreLockedSeq,
  input wire logic priority_bus_request_n,
  output logic lockedHeldByPeer,
  // internal error
  input wire logic coreInternalError,
  input wire logic bus_initialise_n,
  output logic internal_error_out_n,
  output logic shutdownRequest,
  // numeric error
  input wire logic ignore_numeric_error_n,
  input wire logic [31:0] controlRegZero,
  input wire logic fpErrorPending,
  input wire logic fpNoncontrolIssue,
  output logic fpException,
  output logic fpProceed,
  // soft init
  input wire logic softInitN,
  output logic integerRegReset,
  output logic resetVectorStart,
  output logic selfTestRun,
  // local interrupts
  input wire logic [1:0] local_irq_pins,
  input wire logic localCtrlDisable,
  output sideband_pkg::irq_out_s irqOut,
  // interrupt message bus, passed to the controller core
  input wire logic irq_bus_clock,
  input wire logic [1:0] irqBusSerialIn,
  input wire logic [1:0] irqBusTxData,
  input wire logic [1:0] irqBusTxEnable,
  output logic [1:0] irqBusSerialOut,
  output logic [1:0] irqBusSerialOeN,
  output logic [1:0] irqBusRxData,
  output logic irqBusClockToCore,
  // debug probe
  input wire logic probe_request_n,
  input wire logic coreDebugReady,
  output logic probe_ready_n,
  output logic debugEntry
);
  import sideband_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers
  async_in_s syncIn;
  logic resetSeenN;

  sync_level #(.STAGES(`SYNC_STAGES), .RESET_VAL(1'b1)) u_sync_ignore (
    .mclk(mclk),
    .resetn(resetn),
    .asyncIn(ignore_numeric_error_n),
    .syncOut(syncIn.ignoreNumericErrorN)
  );
  sync_level #(.STAGES(`SYNC_STAGES), .RESET_VAL(1'b1)) u_sync_init (
    .mclk(mclk),
    .resetn(resetn),
    .asyncIn(softInitN),
    .syncOut(syncIn.softInitN)
  );
  sync_level #(.STAGES(`SYNC_STAGES), .RESET_VAL(1'b0)) u_sync_irq0 (
    .mclk(mclk),
    .resetn(resetn),
    .asyncIn(local_irq_pins[0]),
    .syncOut(syncIn.localIrqPinZero)
  );
  sync_level #(.STAGES(`SYNC_STAGES), .RESET_VAL(1'b0)) u_sync_irq1 (
    .mclk(mclk),
    .resetn(resetn),
    .asyncIn(local_irq_pins[1]),
    .syncOut(syncIn.localIrqPinOne)
  );

  ////////////////////////////////////////////////////////////////////////////
  // snoop result and stall
  wire stallDrive = coreSnoopValid & coreSnoopStall;
  wire hitDrive = (coreSnoopValid & coreSnoopHit) | stallDrive;
  wire hitModDrive = (coreSnoopValid & coreSnoopModified) | stallDrive;
  logic hitOut_ff;
  logic hitModOut_ff;
  logic peerStall_ff;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      hitOut_ff <= 1'b0;
      hitModOut_ff <= 1'b0;
      peerStall_ff <= 1'b0;
    end
    else
    begin
      hitOut_ff <= hitDrive;
      hitModOut_ff <= hitModDrive;
      // a stall is both lines low together, from any agent
      peerStall_ff <= ~snoopHitInN & ~snoop_hit_modified_in_n;
    end
  end

  assign snoopHitOutN = 1'b0;
  assign snoopHitOeN = ~hitOut_ff;
  assign snoop_hit_modified_out_n = 1'b0;
  assign snoopHitModifiedOeN = ~hitModOut_ff;
  assign peerSnoopStall = peerStall_ff;
  // snoops are answered in every state, soft init included
  assign snoopServiced = coreSnoopValid;

  ////////////////////////////////////////////////////////////////////////////
  // bus lock
  logic lockOut_ff;
  logic peerLock_ff;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      lockOut_ff <= 1'b0;
      peerLock_ff <= 1'b0;
    end
    else
    begin
      lockOut_ff <= coreLockedSeq;
      peerLock_ff <= ~busLockInN & ~lockOut_ff;
    end
  end

  assign busLockOutN = 1'b0;
  assign busLockOeN = ~lockOut_ff;
  // a priority agent must not take the bus while lock is held
  assign lockedHeldByPeer = peerLock_ff | (lockOut_ff & ~priority_bus_request_n);

  ////////////////////////////////////////////////////////////////////////////
  // internal error
  wire syncInitActive = ~syncIn.softInitN;
  wire errClear = ~bus_initialise_n | syncInitActive;
  logic intErr_ff;
  logic shutdown_ff;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      intErr_ff <= 1'b0;
      shutdown_ff <= 1'b0;
    end
    else
    begin
      // a new error wins over a clear in the same cycle
      intErr_ff <= coreInternalError | (intErr_ff & ~errClear);
      shutdown_ff <= coreInternalError & ~intErr_ff;
    end
  end

  assign internal_error_out_n = ~intErr_ff;
  assign shutdownRequest = shutdown_ff;

  ////////////////////////////////////////////////////////////////////////////
  // numeric error
  wire nativeNumErr = controlRegZero[`CR0_NATIVE_ERR_BIT];
  // sampled value is assumed stable by target ready of the io write
  wire ignoreActive = ~syncIn.ignoreNumericErrorN & ~nativeNumErr;
  wire raiseFp = fpNoncontrolIssue & fpErrorPending & ~ignoreActive;
  logic fpExc_ff;
  logic fpProceed_ff;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      fpExc_ff <= 1'b0;
      fpProceed_ff <= 1'b0;
    end
    else
    begin
      fpExc_ff <= raiseFp;
      fpProceed_ff <= fpNoncontrolIssue & ~raiseFp;
    end
  end

  assign fpException = fpExc_ff;
  assign fpProceed = fpProceed_ff;

  ////////////////////////////////////////////////////////////////////////////
  // soft init and self-test
  run_state_e state_ff;
  run_state_e nxt_state;
  logic [1:0] releaseCnt_ff;
  wire [1:0] nxt_releaseCnt = (releaseCnt_ff == 2'h3) ? 2'h3 : releaseCnt_ff + 2'h1;
  // synchroniser resets inactive: strap is read once it shows the real pin level
  wire catchRelease = (releaseCnt_ff == 2'(`SYNC_STAGES));

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      releaseCnt_ff <= 2'h0;
    else
      releaseCnt_ff <= nxt_releaseCnt;
  end

  assign resetSeenN = (releaseCnt_ff != 2'h0);

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN:
      begin
        if (catchRelease && syncInitActive)
          nxt_state = ST_BIST;
        else if (syncInitActive)
          nxt_state = ST_INIT;
      end
      ST_INIT, ST_BIST:
      begin
        if (!syncInitActive)
          nxt_state = ST_RUN;
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  logic vecStart_ff;
  logic bist_ff;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= ST_RUN;
      vecStart_ff <= 1'b0;
      bist_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      vecStart_ff <= (state_ff != ST_RUN) && (nxt_state == ST_RUN);
      bist_ff <= (state_ff == ST_RUN) && (nxt_state == ST_BIST);
    end
  end

  // cache and fp registers untouched: only integer state is reset
  assign integerRegReset = (state_ff != ST_RUN);
  assign resetVectorStart = vecStart_ff;
  assign selfTestRun = bist_ff;

  ////////////////////////////////////////////////////////////////////////////
  // local interrupt pins
  logic ctrlEnable_ff;
  irq_out_s irq_ff;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrlEnable_ff <= `LOCAL_CTRL_RESET_EN;
      irq_ff <= '0;
    end
    else
    begin
      ctrlEnable_ff <= ~localCtrlDisable;
      irq_ff.maskableIrqRequest <= ~ctrlEnable_ff & syncIn.localIrqPinZero;
      irq_ff.nonmaskableIrq <= ~ctrlEnable_ff & syncIn.localIrqPinOne;
      irq_ff.localIrqZero <= ctrlEnable_ff & syncIn.localIrqPinZero;
      irq_ff.localIrqOne <= ctrlEnable_ff & syncIn.localIrqPinOne;
    end
  end

  assign irqOut = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt message bus: pin split only, serial engine lives on its clock
  assign irqBusClockToCore = irq_bus_clock;
  assign irqBusSerialOut = 2'h0;
  assign irqBusSerialOeN = ~(irqBusTxEnable & ~irqBusTxData);
  assign irqBusRxData = irqBusSerialIn;

  ////////////////////////////////////////////////////////////////////////////
  // debug probe
  logic probeReq_ff;
  logic probeRdy_ff;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      probeReq_ff <= 1'b0;
      probeRdy_ff <= 1'b0;
    end
    else
    begin
      probeReq_ff <= ~probe_request_n;
      probeRdy_ff <= probeReq_ff & coreDebugReady & resetSeenN;
    end
  end

  assign probe_ready_n = ~probeRdy_ff;
  assign debugEntry = probeReq_ff & ~probeRdy_ff;
endmodule

//--- testbench/sideband_props.sv
/*
  Concurrent checks on the sideband control block ports.
  Assumes one mclk domain and the constants header on the include path.
*/
`timescale 1ns/10ps
`include "sideband_params.svh"

module sideband_props (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic snoopHitInN,
  input wire logic snoop_hit_modified_in_n,
  input wire logic snoopHitOeN,
  input wire logic snoopHitModifiedOeN,
  input wire logic coreSnoopValid,
  input wire logic coreSnoopStall,
  input wire logic peerSnoopStall,
  input wire logic coreLockedSeq,
  input wire logic busLockOeN,
  input wire logic coreInternalError,
  input wire logic bus_initialise_n,
  input wire logic softInitN,
  input wire logic internal_error_out_n,
  input wire logic shutdownRequest,
  input wire logic ignore_numeric_error_n,
  input wire logic [31:0] controlRegZero,
  input wire logic fpErrorPending,
  input wire logic fpNoncontrolIssue,
  input wire logic fpException,
  input wire logic integerRegReset,
  input wire logic [1:0] local_irq_pins,
  input wire logic localCtrlDisable,
  input wire sideband_pkg::irq_out_s irqOut
);
  import sideband_pkg::*;
  wire fpErr = fpNoncontrolIssue && fpErrorPending;
  wire nativeSet = controlRegZero[`CR0_NATIVE_ERR_BIT];
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // four cycles covers the two-flop synchroniser lag
  sequence ignHeld(v);
    (ignore_numeric_error_n == v)[*4];
  endsequence
  sequence pinsSteady(dis);
    ($stable(local_irq_pins) && localCtrlDisable == dis)[*4];
  endsequence
  sequence errQuiet;
    (softInitN && bus_initialise_n)[*4];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  snoop_stall_a: assert property (coreSnoopValid && coreSnoopStall |=>
    !snoopHitOeN && !snoopHitModifiedOeN) else $error("stall not on both lines");
  peer_stall_a: assert property (!snoopHitInN && !snoop_hit_modified_in_n |=> peerSnoopStall)
    else $error("bus stall missed");
  lock_hold_a: assert property (coreLockedSeq |=> !busLockOeN)
    else $error("lock not held");
  lock_release_a: assert property ($fell(coreLockedSeq) |=> busLockOeN)
    else $error("lock not released");
  error_set_a: assert property (coreInternalError |=> !internal_error_out_n)
    else $error("error not raised");
  error_hold_a: assert property (errQuiet ##0 !internal_error_out_n |=> !internal_error_out_n)
    else $error("error dropped early");
  shutdown_pulse_a: assert property (coreInternalError && internal_error_out_n |=>
    shutdownRequest ##1 !shutdownRequest) else $error("shutdown pulse wrong");
  ignore_on_a: assert property (ignHeld(1'b0) ##0 (fpErr && !nativeSet) |=> !fpException)
    else $error("ignored error trapped");
  except_a: assert property (ignHeld(1'b1) ##0 fpErr |=> fpException)
    else $error("numeric exception missing");
  native_override_a: assert property (fpErr && nativeSet |=> fpException)
    else $error("native mode not trapping");
  init_hold_a: assert property ((!softInitN)[*4] |-> integerRegReset)
    else $error("integer reset missing");
  irq_legacy_a: assert property (pinsSteady(1'b1) |-> irqOut.maskableIrqRequest ==
    local_irq_pins[0] && irqOut.nonmaskableIrq == local_irq_pins[1]) else $error("legacy irq");
  irq_local_a: assert property (pinsSteady(1'b0) |-> irqOut.localIrqZero ==
    local_irq_pins[0] && !irqOut.maskableIrqRequest) else $error("local irq mode");
endmodule

bind processor_sideband_control sideband_props u_sideband_props (.*);

//--- testbench/bus_agent_model.sv
/*
  Other bus agents: wired-low snoop and lock lines, a priority agent.
  Assumes pull-ups on the wired lines; behavioural, no clock needed.
*/
`timescale 1ns/10ps

module bus_agent_model (
  input wire logic snoopHitOeN,
  input wire logic snoopHitModifiedOeN,
  input wire logic busLockOeN,
  input wire logic peerStall,
  input wire logic peerLock,
  input wire logic prioWant,
  output logic snoopHitInN,
  output logic snoop_hit_modified_in_n,
  output logic busLockInN,
  output logic priority_bus_request_n,
  output logic prioOwnsBus
);
  // a peer stall pulls both lines together
  assign snoopHitInN = snoopHitOeN && !peerStall;
  assign snoop_hit_modified_in_n = snoopHitModifiedOeN && !peerStall;
  assign busLockInN = busLockOeN && !peerLock;
  assign priority_bus_request_n = !prioWant;
  assign prioOwnsBus = prioWant && busLockInN;
endmodule

//--- testbench/tb_processor_sideband_control.sv
/*
  Scenario testbench for the sideband control block.
  Assumes the partner model resolves the wired bus lines.
*/
`timescale 1ns/10ps
`include "sideband_params.svh"

module tb_processor_sideband_control;
  import sideband_pkg::*;
  logic mclk = 0, resetn = 0, softInitN = 1, bus_initialise_n = 1, coreInternalError = 0;
  logic coreSnoopValid = 0, coreSnoopHit = 0, coreSnoopModified = 0, coreSnoopStall = 0;
  logic coreLockedSeq = 0, peerStall = 0, peerLock = 0, prioWant = 0, prioOwnsBus;
  logic ignore_numeric_error_n = 1, fpErrorPending = 0, fpNoncontrolIssue = 0;
  logic [31:0] controlRegZero = 32'h0000_0000;
  logic [1:0] local_irq_pins = 2'h0, irqBusSerialIn = 2'h0, irqBusTxData = 2'h0;
  logic [1:0] irqBusTxEnable = 2'h0, irqBusSerialOut, irqBusSerialOeN, irqBusRxData;
  logic localCtrlDisable = 0, irq_bus_clock = 0, probe_request_n = 1, coreDebugReady = 0;
  logic snoopHitInN, snoop_hit_modified_in_n, snoopHitOutN, snoopHitOeN, snoopServiced;
  logic snoop_hit_modified_out_n, snoopHitModifiedOeN, peerSnoopStall, busLockInN;
  logic busLockOutN, busLockOeN, priority_bus_request_n, lockedHeldByPeer, shutdownRequest;
  logic internal_error_out_n, fpException, fpProceed, integerRegReset, resetVectorStart;
  logic selfTestRun, irqBusClockToCore, probe_ready_n, debugEntry;
  irq_out_s irqOut;
  int nFail = 0, samplesChecked = 0;

  processor_sideband_control u_processor_sideband_control (.*);
  bus_agent_model u_agent (.*);

  always #20 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input bit ok, input string m);
    samplesChecked++;
    if (!ok)
    begin
      nFail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic results;
    if (nFail == 0 && samplesChecked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset(input logic init);
    bit seen;
    seen = 0;
    resetn = 0;
    softInitN = !init;
    cyc(16);
    resetn = 1;
    repeat (4)
    begin
      cyc(1);
      seen |= selfTestRun === 1'b1;
    end
    chk(seen == init, "self-test at reset release");
    softInitN = 1;
    cyc(4);
  endtask
  task automatic t_irq;
    local_irq_pins = 2'h1;
    cyc(5);
    chk(irqOut.localIrqZero === 1'b1 && irqOut.maskableIrqRequest === 1'b0, "local mode");
    localCtrlDisable = 1;
    local_irq_pins = 2'h2;
    cyc(5);
    chk(irqOut.nonmaskableIrq === 1'b1 && irqOut.maskableIrqRequest === 1'b0, "nmi pin");
    local_irq_pins = 2'h1;
    cyc(5);
    chk(irqOut.maskableIrqRequest === 1'b1 && irqOut.nonmaskableIrq === 1'b0, "maskable_irq_request pin");
    localCtrlDisable = 0;
  endtask
  task automatic t_snoop;
    {coreSnoopValid, coreSnoopHit, coreSnoopModified, coreSnoopStall} = 4'hF;
    cyc(1);
    chk(snoopHitOeN === 1'b0 && snoopHitModifiedOeN === 1'b0, "own stall");
    cyc(1);
    chk(peerSnoopStall === 1'b1 && snoopServiced === 1'b1, "stall on bus");
    {coreSnoopValid, coreSnoopHit, coreSnoopModified, coreSnoopStall} = 4'h0;
    peerStall = 1;
    cyc(2);
    chk(peerSnoopStall === 1'b1 && snoopHitOeN === 1'b1, "peer stall");
    peerStall = 0;
    cyc(2);
    chk(peerSnoopStall === 1'b0, "stall ended");
  endtask
  task automatic t_lock;
    coreLockedSeq = 1;
    prioWant = 1;
    cyc(2);
    chk(busLockOeN === 1'b0 && prioOwnsBus === 1'b0 && lockedHeldByPeer === 1'b1, "locked");
    coreLockedSeq = 0;
    cyc(2);
    chk(busLockOeN === 1'b1 && prioOwnsBus === 1'b1, "lock released");
    prioWant = 0;
    peerLock = 1;
    cyc(2);
    chk(lockedHeldByPeer === 1'b1 && busLockOeN === 1'b1, "peer lock");
    peerLock = 0;
    cyc(2);
  endtask
  task automatic t_error;
    coreInternalError = 1;
    cyc(1);
    coreInternalError = 0;
    chk(internal_error_out_n === 1'b0 && shutdownRequest === 1'b1, "error raised");
    cyc(6);
    chk(internal_error_out_n === 1'b0 && shutdownRequest === 1'b0, "error held");
    bus_initialise_n = 0;
    cyc(3);
    bus_initialise_n = 1;
    chk(internal_error_out_n === 1'b1, "bus init clear");
    coreInternalError = 1;
    cyc(1);
    coreInternalError = 0;
    softInitN = 0;
    cyc(4);
    chk(internal_error_out_n === 1'b1, "soft init clear");
    softInitN = 1;
    cyc(4);
  endtask
  task automatic t_numeric;
    logic e;
    fpErrorPending = 1;
    for (int k = 0; k < 4; k++)
    begin
      ignore_numeric_error_n = k[0];
      controlRegZero[`CR0_NATIVE_ERR_BIT] = k[1];
      e = k[0] | k[1];
      cyc(4);
      fpNoncontrolIssue = 1;
      cyc(1);
      fpNoncontrolIssue = 0;
      chk(fpException === e && fpProceed === !e, "numeric error");
    end
    fpErrorPending = 0;
  endtask
  task automatic t_init;
    bit seen;
    seen = 0;
    coreSnoopValid = 1;
    softInitN = 0;
    cyc(4);
    chk(integerRegReset === 1'b1 && snoopServiced === 1'b1, "soft init");
    softInitN = 1;
    coreSnoopValid = 0;
    repeat (5)
    begin
      cyc(1);
      seen |= resetVectorStart === 1'b1;
    end
    chk(seen && integerRegReset === 1'b0, "restart");
  endtask
  task automatic t_probe_bus;
    coreDebugReady = 1;
    probe_request_n = 0;
    {irqBusTxEnable, irqBusTxData, irqBusSerialIn} = 6'h39;
    irq_bus_clock = 1;
    cyc(1);
    chk(debugEntry === 1'b1 && probe_ready_n === 1'b1, "debug entry");
    cyc(2);
    chk(probe_ready_n === 1'b0 && debugEntry === 1'b0, "probe ready");
    chk(snoopHitOutN === 1'b0 && snoop_hit_modified_out_n === 1'b0 && busLockOutN === 1'b0
      && irqBusSerialOut === 2'h0, "wired-low drive");
    chk(irqBusSerialOeN === 2'h2 && irqBusRxData === 2'h1 && irqBusClockToCore === 1'b1, "irq bus");
    probe_request_n = 1;
    irqBusTxEnable = 2'h0;
    irq_bus_clock = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    t_reset(1'b0);
    t_irq();
    t_snoop();
    t_lock();
    t_error();
    t_numeric();
    t_init();
    t_probe_bus();
    t_reset(1'b1);
    results();
  end
  // whole run is about 130 cycles
  initial
  begin
    repeat (3000) @(posedge mclk);
    nFail++;
    results();
  end
endmodule
